// ### verilog/ahp_host_port.sv
`timescale 1ns/100ps
// How it works
// - Select pin low: clock pin is an input, external master clock used.
// - Select pin high: internal oscillator; pin driven only when output enable set.
// - Each channel result is a 24-bit twos-complement word, sent MSB first.
// - Results clip to 7fffff above and 800000 below full scale.
// - Zero input is code zero; one LSB up 000001, one down all ones.
// - Four-wire port reads results, reads and writes registers, takes commands.
// - Data-ready output goes low when a new result set is available.
// - Select high resets port, ignores clock and data-in, floats data-out.
// - Data-ready asserts on conversion completion regardless of chip select.
// - Data-in bits are sampled on each falling serial clock edge.
// - Read data shifts onto data-out at each rising serial clock edge.
// - Frame is 216 bits: status 1100, lead-off, GPIO, then eight channels.
// - Data-ready returns high at the first falling serial clock edge.
module ahp_host_port import ahp_pkg::*; (
   input wire logic CORE_CLK, // core clock, 25 MHz
   input wire logic RST, // synchronous reset, active high
   input wire logic CS_N, // chip select pin, active low
   input wire logic SCLK, // serial clock pin
   input wire logic DIN, // serial data-in pin
   output logic DOUT_O, // serial data-out level
   output logic DOUT_OE, // serial data-out enable
   input wire logic CLOCK_SOURCE_SELECT_PIN, // high selects the internal oscillator
   input wire logic CLK_OUT_EN, // clock output enable bit of the first configuration register
   input wire logic OSC_CLK, // internal oscillator clock
   input wire logic CLK_PIN_I, // clock pin level seen at the pad
   output logic CLK_PIN_O, // clock pin drive level
   output logic CLK_PIN_OE, // clock pin drive enable
   output logic MASTER_CLK_O, // chosen master clock level
   output logic INT_CLK_SEL, // high while running from the oscillator
   input wire logic CONV_DONE, // one-cycle pulse, a new result set is ready
   input wire logic [CH_NUM*RAW_BITS-1:0] CH_RAW, // filter outputs, channel 1 highest
   input wire ahp_status_t STATUS, // lead-off and GPIO levels
   input wire logic CONTINUOUS_READ_MODE, // continuous read mode is active
   input wire logic RESULT_READ, // a single result read is in progress
   input wire logic [7:0] REG_RD_DATA, // register byte to shift out
   output logic RESULT_AVAILABLE_N, // data-ready, active low
   output logic [7:0] RX_BYTE, // last byte received on data-in
   output logic RX_VALID // one-cycle pulse with each received byte
);
   ahp_state_t st_r;
   ahp_state_t st_nxt;
   logic [SYNC_W-1:0] sync_s;
   logic [CH_NUM*CH_BITS-1:0] codes;
   logic cs_s;
   logic sclk_s;
   logic rise;
   logic fall;
   logic data_mode;

   // Every pin passes two flops before the port logic reads it.
   ahp_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .d({OSC_CLK, CLK_PIN_I, CLOCK_SOURCE_SELECT_PIN, DIN, SCLK, CS_N}),
      .q(sync_s)
   );

   ahp_sat #(.CH(CH_NUM), .RW(RAW_BITS)) u_sat (
      .raw(CH_RAW),
      .code(codes)
   );

   assign cs_s = sync_s[S_CS];
   assign sclk_s = sync_s[S_SCLK];
   // Edges are seen only while selected, so serial activity is ignored otherwise.
   assign rise = !cs_s && sclk_s && !st_r.sclk_d;
   assign fall = !cs_s && !sclk_s && st_r.sclk_d;
   assign data_mode = CONTINUOUS_READ_MODE || RESULT_READ;

   always_comb begin
      st_nxt = st_r;
      st_nxt.cs_d = cs_s;
      st_nxt.sclk_d = sclk_s;
      st_nxt.rx_valid = 1'b0;

      // The snapshot lets a read overlap the next conversion without tearing.
      if (CONV_DONE) begin
         st_nxt.frame = {STAT_HDR, STATUS, codes};
      end

      if (cs_s) begin
         // Deselect clears the port, including a half-clocked command.
         st_nxt.rcnt = BIT_FIRST;
         st_nxt.tcnt = BIT_FIRST;
         st_nxt.rx = '0;
         st_nxt.dout = 1'b0;
         st_nxt.dout_oe = 1'b0;
      end else begin
         st_nxt.dout_oe = 1'b1;
         if (st_r.cs_d) begin
            st_nxt.sr = st_r.frame;
         end
         if (rise) begin
            if (data_mode) begin
               // Rotation repeats the frame when more clocks are given.
               st_nxt.dout = st_r.sr[FRAME_BITS-1];
               st_nxt.sr = {st_r.sr[FRAME_BITS-2:0], st_r.sr[FRAME_BITS-1]};
            end else if (st_r.tcnt == BIT_FIRST) begin
               st_nxt.dout = REG_RD_DATA[7];
               st_nxt.tx = {REG_RD_DATA[6:0], 1'b0};
               st_nxt.tcnt = st_r.tcnt + 3'h1;
            end else begin
               st_nxt.dout = st_r.tx[7];
               st_nxt.tx = {st_r.tx[6:0], 1'b0};
               st_nxt.tcnt = st_r.tcnt + 3'h1;
            end
         end
         if (fall) begin
            st_nxt.rx = {st_r.rx[6:0], sync_s[S_DIN]};
            st_nxt.rcnt = st_r.rcnt + 3'h1;
            if (st_r.rcnt == BIT_LAST) begin
               st_nxt.rx_byte = {st_r.rx[6:0], sync_s[S_DIN]};
               st_nxt.rx_valid = 1'b1;
            end
         end
      end

      // A completion in the same cycle as a falling edge keeps data-ready low.
      if (CONV_DONE) begin
         st_nxt.result_available_n_n = 1'b0;
      end else if (fall) begin
         st_nxt.result_available_n_n = 1'b1;
      end

      st_nxt.int_sel = sync_s[S_SEL];
      st_nxt.clk_oe = sync_s[S_SEL] && CLK_OUT_EN;
      st_nxt.clk_o = sync_s[S_SEL] && sync_s[S_OSC];
      st_nxt.mclk = sync_s[S_SEL] ? sync_s[S_OSC] : sync_s[S_CLKI];
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_r <= '0;
         st_r.cs_d <= 1'b1;
         st_r.result_available_n_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign DOUT_O = st_r.dout;
   assign DOUT_OE = st_r.dout_oe;
   assign CLK_PIN_O = st_r.clk_o;
   assign CLK_PIN_OE = st_r.clk_oe;
   assign MASTER_CLK_O = st_r.mclk;
   assign INT_CLK_SEL = st_r.int_sel;
   assign RESULT_AVAILABLE_N = st_r.result_available_n_n;
   assign RX_BYTE = st_r.rx_byte;
   assign RX_VALID = st_r.rx_valid;

   a_result_available_n_set_low: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE |=> !RESULT_AVAILABLE_N)
      else $error("data-ready did not go low after a conversion");

   a_result_available_n_ignores_cs: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE && cs_s |=> !RESULT_AVAILABLE_N && !DOUT_OE)
      else $error("data-ready depended on chip select");

   a_result_available_n_fall_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
      fall && !CONV_DONE |=> RESULT_AVAILABLE_N)
      else $error("data-ready not released at falling clock edge");

   a_dout_float: assert property (@(posedge CORE_CLK) disable iff (RST)
      cs_s |=> !DOUT_OE && st_r.rcnt == BIT_FIRST)
      else $error("data-out driven or port not reset while deselected");

   a_dout_rise_shift: assert property (@(posedge CORE_CLK) disable iff (RST)
      rise && data_mode |=> DOUT_O == $past(st_r.sr[FRAME_BITS-1]))
      else $error("data-out did not take the next frame bit");

   a_rx_byte_done: assert property (@(posedge CORE_CLK) disable iff (RST)
      fall && st_r.rcnt == BIT_LAST |=> RX_VALID && RX_BYTE[0] == $past(sync_s[S_DIN]))
      else $error("received byte not delivered on eighth falling edge");

   a_clk_ext_input: assert property (@(posedge CORE_CLK) disable iff (RST)
      !sync_s[S_SEL] |=> !CLK_PIN_OE && !INT_CLK_SEL)
      else $error("clock pin driven with external clock selected");

   a_clk_int_drive: assert property (@(posedge CORE_CLK) disable iff (RST)
      sync_s[S_SEL] |=> CLK_PIN_OE == $past(CLK_OUT_EN) && INT_CLK_SEL)
      else $error("clock pin enable does not follow the output enable bit");

   a_frame_header: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE |=> st_r.frame[FRAME_BITS-1 -: 4] == STAT_HDR)
      else $error("frame status header wrong");

   a_clip_positive: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE && !CH_RAW[CH_NUM*RAW_BITS-1]
         && CH_RAW[CH_NUM*RAW_BITS-2 -: RAW_BITS-CH_BITS] != '0
      |=> st_r.frame[CH_NUM*CH_BITS-1 -: CH_BITS] == CODE_MAX)
      else $error("channel 1 did not clip to the top code");

   a_clip_negative: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE && CH_RAW[CH_NUM*RAW_BITS-1]
         && CH_RAW[CH_NUM*RAW_BITS-2 -: RAW_BITS-CH_BITS] != '1
      |=> st_r.frame[CH_NUM*CH_BITS-1 -: CH_BITS] == CODE_MIN)
      else $error("channel 1 did not clip to the bottom code");

   // The checks below pin each output down one cycle after its cause.
   a_clk_pin_level: assert property (@(posedge CORE_CLK) disable iff (RST)
      sync_s[S_SEL]
      |=> CLK_PIN_O == $past(sync_s[S_OSC]))
      else $error("clock pin level does not follow the oscillator");

   a_clk_pin_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
      !sync_s[S_SEL]
      |=> !CLK_PIN_O)
      else $error("clock pin level driven with external clock selected");

   a_mclk_external: assert property (@(posedge CORE_CLK) disable iff (RST)
      !sync_s[S_SEL]
      |=> MASTER_CLK_O == $past(sync_s[S_CLKI]))
      else $error("master clock does not follow the clock pin");

   a_mclk_internal: assert property (@(posedge CORE_CLK) disable iff (RST)
      sync_s[S_SEL]
      |=> MASTER_CLK_O == $past(sync_s[S_OSC]))
      else $error("master clock does not follow the oscillator");

   a_dout_drive_sel: assert property (@(posedge CORE_CLK) disable iff (RST)
      !cs_s
      |=> DOUT_OE)
      else $error("data-out not driven while selected");

   a_dout_idle_low: assert property (@(posedge CORE_CLK) disable iff (RST)
      cs_s
      |=> !DOUT_O && st_r.tcnt == BIT_FIRST)
      else $error("transmit side not reset while deselected");

   a_rx_quiet_desel: assert property (@(posedge CORE_CLK) disable iff (RST)
      cs_s
      |=> !RX_VALID)
      else $error("byte received while deselected");

   a_result_available_n_hold_low: assert property (@(posedge CORE_CLK) disable iff (RST)
      !RESULT_AVAILABLE_N && !fall
      |=> !RESULT_AVAILABLE_N)
      else $error("data-ready released without a falling clock edge");

   a_result_available_n_only_conv: assert property (@(posedge CORE_CLK) disable iff (RST)
      RESULT_AVAILABLE_N && !CONV_DONE
      |=> RESULT_AVAILABLE_N)
      else $error("data-ready asserted without a conversion");

   a_reg_first_bit: assert property (@(posedge CORE_CLK) disable iff (RST)
      rise && !data_mode && st_r.tcnt == BIT_FIRST
      |=> DOUT_O == $past(REG_RD_DATA[7]))
      else $error("register byte did not start with its top bit");

   a_reg_next_bit: assert property (@(posedge CORE_CLK) disable iff (RST)
      rise && !data_mode && st_r.tcnt != BIT_FIRST
      |=> DOUT_O == $past(st_r.tx[7]))
      else $error("register byte bit order wrong");

   a_tx_count_step: assert property (@(posedge CORE_CLK) disable iff (RST)
      rise && !data_mode
      |=> st_r.tcnt == $past(st_r.tcnt) + 3'h1)
      else $error("transmit bit count did not advance");

   a_dout_steady: assert property (@(posedge CORE_CLK) disable iff (RST)
      !rise && !cs_s
      |=> $stable(DOUT_O))
      else $error("data-out changed without a rising clock edge");

   a_rx_bit_take: assert property (@(posedge CORE_CLK) disable iff (RST)
      fall
      |=> st_r.rx[0] == $past(sync_s[S_DIN]))
      else $error("data-in bit not taken at falling clock edge");

   a_rx_count_step: assert property (@(posedge CORE_CLK) disable iff (RST)
      fall
      |=> st_r.rcnt == $past(st_r.rcnt) + 3'h1)
      else $error("receive bit count did not advance");

   a_rx_no_take: assert property (@(posedge CORE_CLK) disable iff (RST)
      !fall && !cs_s
      |=> $stable(st_r.rcnt))
      else $error("receive bit count moved without a falling edge");

   a_frame_status: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE
      |=> st_r.frame[FRAME_BITS-5 -: 20] == $past(STATUS))
      else $error("frame status bits do not match the status inputs");

   a_code_pass: assert property (@(posedge CORE_CLK) disable iff (RST)
      CONV_DONE && (CH_RAW[CH_NUM*RAW_BITS-1 -: 3] == 3'h0
         || CH_RAW[CH_NUM*RAW_BITS-1 -: 3] == 3'h7)
      |=> st_r.frame[CH_NUM*CH_BITS-1 -: CH_BITS] == $past(CH_RAW[CH_NUM*RAW_BITS-3 -: CH_BITS]))
      else $error("in-range channel 1 result altered");

   a_frame_keep: assert property (@(posedge CORE_CLK) disable iff (RST)
      !CONV_DONE
      |=> $stable(st_r.frame))
      else $error("frame snapshot changed without a conversion");

   a_sr_load: assert property (@(posedge CORE_CLK) disable iff (RST)
      st_r.cs_d && !cs_s && !rise
      |=> st_r.sr == $past(st_r.frame))
      else $error("shifter not loaded from the snapshot at select");

   a_frame_rotate: assert property (@(posedge CORE_CLK) disable iff (RST)
      rise && data_mode
      |=> st_r.sr[0] == $past(st_r.sr[FRAME_BITS-1]))
      else $error("frame did not rotate back to its first bit");
endmodule // ahp_host_port

// ### verilog/ahp_pkg.sv
package ahp_pkg;
   localparam int CH_NUM = 8;
   localparam int CH_BITS = 24;
   localparam int RAW_BITS = 26;
   localparam int STAT_BITS = 24;
   localparam int FRAME_BITS = STAT_BITS + CH_NUM * CH_BITS;
   localparam logic [3:0] STAT_HDR = 4'hc;
   localparam logic [23:0] CODE_MAX = 24'h7fffff;
   localparam logic [23:0] CODE_MIN = 24'h800000;
   localparam logic [23:0] CODE_ZERO = 24'h000000;
   localparam int SYNC_W = 6;
   // Synchronisers start at the idle pin levels, chip select high, so reset shows no select.
   localparam logic [SYNC_W-1:0] SYNC_INIT = 6'h01;
   localparam int S_CS = 0;
   localparam int S_SCLK = 1;
   localparam int S_DIN = 2;
   localparam int S_SEL = 3;
   localparam int S_CLKI = 4;
   localparam int S_OSC = 5;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;

   typedef struct packed {
      logic [7:0] loff_p;
      logic [7:0] loff_n;
      logic [3:0] gpio;
   } ahp_status_t;

   typedef struct packed {
      logic cs_d;
      logic sclk_d;
      logic [FRAME_BITS-1:0] frame;
      logic [FRAME_BITS-1:0] sr;
      logic [7:0] tx;
      logic [2:0] tcnt;
      logic [7:0] rx;
      logic [2:0] rcnt;
      logic [7:0] rx_byte;
      logic rx_valid;
      logic dout;
      logic dout_oe;
      logic result_available_n_n;
      logic clk_o;
      logic clk_oe;
      logic mclk;
      logic int_sel;
   } ahp_state_t;
endpackage

// ### verilog/ahp_sync.sv
`timescale 1ns/100ps
module ahp_sync import ahp_pkg::*; #(
   parameter int W = SYNC_W,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk, // sampling clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] d, // asynchronous levels
   output logic [W-1:0] q // synchronised levels
);
   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // ahp_sync

// ### verilog/ahp_sat.sv
`timescale 1ns/100ps
module ahp_sat import ahp_pkg::*; #(
   parameter int CH = CH_NUM,
   parameter int RW = RAW_BITS
) (
   input wire logic [CH*RW-1:0] raw, // signed filter outputs, channel 1 highest
   output logic [CH*CH_BITS-1:0] code // clipped result words, channel 1 highest
);
   genvar i;
   generate
      for (i = 0; i < CH; i++) begin : g_ch
         logic signed [RW-1:0] v;
         logic [CH_BITS-1:0] clip;
         assign v = $signed(raw[i*RW +: RW]);
         // Anything past full scale clips to the end codes.
         always_comb begin
            if (v > $signed({{(RW-CH_BITS){1'b0}}, CODE_MAX})) begin
               clip = CODE_MAX;
            end else if (v < $signed({{(RW-CH_BITS){1'b1}}, CODE_MIN})) begin
               clip = CODE_MIN;
            end else begin
               clip = v[CH_BITS-1:0];
            end
         end
         assign code[i*CH_BITS +: CH_BITS] = clip;
      end
   endgenerate
endmodule // ahp_sat

// ### dv/ahp_spi_host.sv
`timescale 1ns/100ps
module ahp_spi_host import ahp_pkg::*; (
   input wire logic clk, // core clock that paces the pins
   input wire logic dout, // data-out wire level
   output logic cs_n, // chip select, active low
   output logic sclk, // serial clock
   output logic din // serial data-in
);
   logic [FRAME_BITS-1:0] rx_r;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
      rx_r = '0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Four core clocks a phase give a 320 ns serial period.
   task automatic xfer(input int n, input logic [7:0] tx);
      cs_n = 1'b0;
      wait_clk(6);
      for (int i = 0; i < n; i++) begin
         din = tx[7 - (i % 8)];
         sclk = 1'b1;
         wait_clk(4);
         rx_r = {rx_r[FRAME_BITS-2:0], dout};
         sclk = 1'b0;
         wait_clk(4);
      end
      wait_clk(5);
      cs_n = 1'b1;
      din = ~din;
      // Let the deselect reach the port before anything else is driven.
      wait_clk(4);
   endtask
   // Clocks and data while deselected must be ignored by the port.
   task automatic noise();
      for (int i = 0; i < 8; i++) begin
         sclk = 1'b1;
         din = ~din;
         wait_clk(4);
         sclk = 1'b0;
         wait_clk(4);
      end
   endtask
endmodule // ahp_spi_host

// ### dv/ahp_host_port_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module ahp_host_port_tb_top import ahp_pkg::*;;
   logic clk = 1'b0, rst = 1'b1, sel = 1'b0, en = 1'b0, osc = 1'b0, pad = 1'b0;
   logic conv = 1'b0, cont = 1'b0, rdr = 1'b0, dout_o, dout_oe, dout_last = 1'b0;
   logic [7:0] reg_d = 8'h00;
   logic [CH_NUM*RAW_BITS-1:0] raw = '0;
   ahp_status_t stat = '0;
   logic cs_n, sclk, din, pin_o, pin_oe, mclk, isel, result_available_n_n, rxv;
   logic [7:0] rxb;
   wire dout_w = dout_oe ? dout_o : ~dout_last;
   int errors = 0, tests_run = 0, nvalid = 0, n0;
   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (dout_oe) dout_last <= dout_o;
      if (rxv === 1'b1) nvalid <= nvalid + 1;
   end
   ahp_spi_host host (.clk(clk), .dout(dout_w), .cs_n(cs_n), .sclk(sclk), .din(din));
   ahp_host_port uut (.CORE_CLK(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
      .DOUT_O(dout_o), .DOUT_OE(dout_oe), .CLOCK_SOURCE_SELECT_PIN(sel), .CLK_OUT_EN(en),
      .OSC_CLK(osc), .CLK_PIN_I(pad), .CLK_PIN_O(pin_o), .CLK_PIN_OE(pin_oe),
      .MASTER_CLK_O(mclk), .INT_CLK_SEL(isel), .CONV_DONE(conv), .CH_RAW(raw),
      .STATUS(stat), .CONTINUOUS_READ_MODE(cont), .RESULT_READ(rdr), .REG_RD_DATA(reg_d),
      .RESULT_AVAILABLE_N(result_available_n_n), .RX_BYTE(rxb), .RX_VALID(rxv));
   task automatic test_done();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         host.wait_clk(1);
         `CHK(dout_oe, 1'b0)
         `CHK(result_available_n_n, 1'b1)
      end
      `CHK({rxv, rxb}, 9'h000)
      $display("test reset done");
   endtask
   task automatic t_clock();
      for (int i = 0; i < 3; i++) begin
         sel = (i != 0);
         en = (i != 1);
         osc = i[0];
         pad = ~i[0];
         host.wait_clk(4);
         `CHK(isel, sel)
         `CHK(pin_oe, sel & en)
         `CHK(mclk, sel ? osc : pad)
         `CHK(pin_o, sel & osc)
      end
      $display("test clock done");
   endtask
   task automatic t_frame();
      raw = {26'h1000000, 26'h2000000, 26'h07fffff, 26'h0000001,
             26'h0000000, 26'h3ffffff, 26'h3800000, 26'h37fffff};
      stat = '{loff_p: 8'h5a, loff_n: 8'h81, gpio: 4'h9};
      conv = 1'b1;
      host.wait_clk(1);
      conv = 1'b0;
      for (int k = 0; k < 3 && result_available_n_n !== 1'b0; k++) host.wait_clk(1);
      host.wait_clk(6);
      `CHK(result_available_n_n, 1'b0)
      rdr = 1'b1;
      host.xfer(FRAME_BITS, 8'h00);
      `CHK(host.rx_r, {STAT_HDR, 20'h5a819, 24'h7fffff, 24'h800000, 24'h7fffff, 24'h000001,
         24'h000000, 24'hffffff, 24'h800000, 24'h800000})
      `CHK(result_available_n_n, 1'b1)
      rdr = 1'b0;
      cont = 1'b1;
      host.xfer(24, 8'h00);
      `CHK(host.rx_r[23:0], {STAT_HDR, 20'h5a819})
      raw = {8{26'h0123456}};
      stat = '{loff_p: 8'ha3, loff_n: 8'h3c, gpio: 4'h6};
      conv = 1'b1;
      host.wait_clk(1);
      conv = 1'b0;
      `CHK(result_available_n_n, 1'b0)
      host.xfer(48, 8'h00);
      `CHK(host.rx_r[47:0], {STAT_HDR, 20'ha33c6, 24'h123456})
      `CHK(result_available_n_n, 1'b1)
      cont = 1'b0;
      $display("test frame done");
   endtask
   task automatic t_register();
      n0 = nvalid;
      reg_d = 8'ha5;
      host.xfer(8, 8'h3c);
      `CHK(host.rx_r[7:0], 8'ha5)
      `CHK(rxb, 8'h3c)
      reg_d = 8'h5a;
      host.xfer(16, 8'hc3);
      `CHK(host.rx_r[15:0], 16'h5a5a)
      `CHK(rxb, 8'hc3)
      `CHK(nvalid, n0 + 3)
      $display("test register done");
   endtask
   task automatic t_deselect();
      n0 = nvalid;
      host.noise();
      `CHK(nvalid, n0)
      `CHK(dout_oe, 1'b0)
      host.xfer(5, 8'hff);
      host.xfer(8, 8'h81);
      `CHK(rxb, 8'h81)
      `CHK(nvalid, n0 + 1)
      $display("test deselect done");
   endtask
   // A reset in mid-run must drop a pending data-ready and the last byte.
   task automatic t_mid_reset();
      conv = 1'b1;
      host.wait_clk(1);
      conv = 1'b0;
      `CHK(result_available_n_n, 1'b0)
      rst = 1'b1;
      host.wait_clk(3);
      rst = 1'b0;
      t_reset();
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done();
   end
   initial begin
      host.wait_clk(6);
      rst = 1'b0;
      t_reset();
      t_clock();
      t_frame();
      t_register();
      t_deselect();
      t_mid_reset();
      test_done();
   end
endmodule // ahp_host_port_tb_top
